// ===== src/assc_sequencer_ctl.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Each result is a 32-bit FIFO word, value in the low 10 bits.
// - Four independent sequencers, one to eight steps, each with own FIFO.
// - Each step has a 4-bit input select and a 4-bit control nibble.
// - Sequencer runs only when enabled; settings stay writable when disabled.
// - The same input may be selected by several steps of one sequence.
// - Every step with its interrupt enable set raises the sequencer event.
// - Sequence ends after the step carrying end-of-sequence; no more steps.
// - FIFO is circular; reading the result address pops the oldest entry.
// - FIFO status shows head and tail pointers, full and empty.
// - Overflow and underflow recorded per sequencer in two registers.
// - Converter clock is divided down, divider picked from crystal select.
// - Event reaches interrupt controller only when its gate bit is set.
// - Raw status shows ungated events; masked status is raw AND gate.
// - Writing 1 to masked status clears that pending event; 0 does nothing.
// - Concurrent triggers served by priority value, 0 highest.
// - Per-sequencer trigger field, including software and always triggers.
// - Software initiate bit starts a sequencer set to software trigger.
// - Always trigger retriggers forever and may starve lower priorities.
// - Averager accumulates up to 64 conversions into one FIFO entry.
// - After reset averaging is off; results pass straight to the FIFO.
// - One averager, same count for all channels, sequencers and modes.
// - After reset sequencer 0 is highest priority, 3 lowest.
module assc_sequencer_ctl
#(
    parameter int STEPS  [4] = '{8, 4, 4, 1},
    parameter int FDEPTH [4] = '{8, 4, 4, 1}
)
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    // Register bus
    input  wire assc_pkg::assc_apb_req_t apbIn,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Peripheral triggers and crystal selection
    input  wire logic [3:0]              extTrig,
    input  wire logic [1:0]              xtalSel,
    // Converter core
    output assc_pkg::assc_conv_req_t     convReq,
    input  wire logic                    convDone,
    input  wire logic [9:0]              convData,
    output logic                         convClk,
    // Interrupt controller
    output logic [3:0]                   irqOut
);
    import assc_pkg::*;

    // Register state
    logic [3:0]        actEn_ff, im_ff, ris_ff, ovf_ff, unf_ff;
    logic [15:0]       emux_ff, pri_ff;
    logic [2:0]        sac_ff;
    logic [31:0]       mux_ff [NSEQ];
    logic [31:0]       ctl_ff [NSEQ];
    // Engine state
    assc_state_t       state_ff;
    logic [1:0]        cur_ff;
    logic [2:0]        step_ff;
    logic [6:0]        avgCnt_ff;
    logic [15:0]       acc_ff;
    logic [3:0]        pending_ff;
    // Bus answer, converter request, interrupt and divider state
    logic [31:0]       prdata_ff;
    logic              pready_ff, pslverr_ff, popOk_ff;
    assc_conv_req_t    convReq_ff;
    logic [3:0]        irq_ff, divCnt_ff;
    logic              convClk_ff;
    // Combinational
    logic              setup, access, wrEn, rdAcc, hit;
    logic [31:0]       rdVal;
    logic [3:0]        trigHit, startMask, risSet, ovfSet, unfSet;
    logic [3:0]        fifoFull, fifoEmpty, popMask;
    logic [9:0]        fifoHead [NSEQ];
    logic [31:0]       fstat [NSEQ];
    logic [1:0]        pick;
    logic              anyPick, pushEn, stepEnd;
    logic [3:0]        curCtl, curMux;
    logic [9:0]        avgOut;
    logic [3:0]        iscClr;
    logic [1:0]        busSeq;

    function automatic logic inSeq(input logic [11:0] a);
        inSeq = (a >= OFF_SEQ) && (a < OFF_SEQ + SEQ_SPAN);
    endfunction : inSeq

    function automatic logic [1:0] seqOf(input logic [11:0] a);
        logic [11:0] d;
        d = a - OFF_SEQ;
        seqOf = d[SEQ_SHIFT+1:SEQ_SHIFT];
    endfunction : seqOf

    function automatic logic [1:0] priOf(input logic [15:0] p,
                                         input int s);
        priOf = p[4*s +: 2];
    endfunction : priOf

    // APB phases: no wait state, answer in the first access cycle
    assign setup  = apbIn.psel && !apbIn.penable;
    assign access = apbIn.psel && apbIn.penable && pready_ff;
    assign wrEn   = access && apbIn.pwrite;
    assign rdAcc  = access && !apbIn.pwrite;

    // Address decode and read data
    always_comb
    begin
        logic [4:0] sub;
        logic [1:0] s;
        sub = apbIn.paddr[4:0];
        s   = seqOf(apbIn.paddr);
        rdVal = 32'h0;
        hit   = 1'b1;
        if (inSeq(apbIn.paddr))
        begin
            if (sub == SUB_MUX)
                rdVal = mux_ff[s];
            else if (sub == SUB_CTL)
                rdVal = ctl_ff[s];
            else if (sub == SUB_FIFO)
                rdVal = {22'h0, fifoHead[s]};
            else if (sub == SUB_FSTAT)
                rdVal = fstat[s];
            else
                hit = 1'b0;
        end
        else if (apbIn.paddr == OFF_ACT)
            rdVal = {28'h0, actEn_ff};
        else if (apbIn.paddr == OFF_RIS)
            rdVal = {28'h0, ris_ff};
        else if (apbIn.paddr == OFF_IM)
            rdVal = {28'h0, im_ff};
        else if (apbIn.paddr == OFF_ISC)
            rdVal = {28'h0, ris_ff & im_ff};
        else if (apbIn.paddr == OFF_OSTAT)
            rdVal = {28'h0, ovf_ff};
        else if (apbIn.paddr == OFF_EMUX)
            rdVal = {16'h0, emux_ff};
        else if (apbIn.paddr == OFF_USTAT)
            rdVal = {28'h0, unf_ff};
        else if (apbIn.paddr == OFF_PRI)
            rdVal = {16'h0, pri_ff};
        else if (apbIn.paddr == OFF_PSSI)
            rdVal = 32'h0;                             // Write-only
        else if (apbIn.paddr == OFF_SAC)
            rdVal = {29'h0, sac_ff};
        else
            hit = 1'b0;
    end

    // Bus answer; data and pop permission caught in the setup cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            popOk_ff   <= 1'b0;
        end
        else
        begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !hit;
            if (setup)
            begin
                prdata_ff <= apbIn.pwrite ? 32'h0 : rdVal;
                popOk_ff  <= !fifoEmpty[seqOf(apbIn.paddr)];
            end
        end
    end

    // Software configuration; writable whether or not a sequencer runs
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            actEn_ff <= 4'h0;
            im_ff    <= 4'h0;
            emux_ff  <= 16'h0;
            pri_ff   <= RST_PRI;
            sac_ff   <= RST_SAC;
            for (int i = 0; i < NSEQ; i++)
            begin
                mux_ff[i] <= 32'h0;
                ctl_ff[i] <= 32'h0;
            end
        end
        else if (wrEn)
        begin
            if (inSeq(apbIn.paddr))
            begin
                if (apbIn.paddr[4:0] == SUB_MUX)
                    mux_ff[seqOf(apbIn.paddr)] <= apbIn.pwdata;
                else if (apbIn.paddr[4:0] == SUB_CTL)
                    ctl_ff[seqOf(apbIn.paddr)] <= apbIn.pwdata;
            end
            else if (apbIn.paddr == OFF_ACT)
                actEn_ff <= apbIn.pwdata[3:0];
            else if (apbIn.paddr == OFF_IM)
                im_ff <= apbIn.pwdata[3:0];
            else if (apbIn.paddr == OFF_EMUX)
                emux_ff <= apbIn.pwdata[15:0];
            else if (apbIn.paddr == OFF_PRI)
                pri_ff <= apbIn.pwdata[15:0] & PRI_MASK;
            else if (apbIn.paddr == OFF_SAC)
                sac_ff <= (apbIn.pwdata[2:0] > SAC_MAX) ? SAC_MAX
                                                        : apbIn.pwdata[2:0];
        end
    end

    // Trigger selection per sequencer
    generate
        for (genvar s = 0; s < NSEQ; s++)
        begin : g_trig
            logic [3:0] code;
            assign code = emux_ff[4*s +: 4];
            always_comb
            begin
                if (code == TRIG_ALWAYS)
                    trigHit[s] = 1'b1;
                else if (code == TRIG_SW)
                    trigHit[s] = wrEn && (apbIn.paddr == OFF_PSSI)
                                 && apbIn.pwdata[s];
                else if (code >= TRIG_EXT_LO && code <= TRIG_EXT_HI)
                    trigHit[s] = extTrig[2'(code - TRIG_EXT_LO)];
                else
                    trigHit[s] = 1'b0;
            end
        end
    endgenerate

    // Pending triggers; a new trigger wins over the start that clears it
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pending_ff <= 4'h0;
        else
            pending_ff <= ((pending_ff & ~startMask) | trigHit)
                          & actEn_ff;
    end

    // Priority pick among enabled pending sequencers
    always_comb
    begin
        pick    = 2'd0;
        anyPick = 1'b0;
        for (int s = 0; s < NSEQ; s++)
        begin
            if (pending_ff[s] && actEn_ff[s] &&
                (!anyPick || priOf(pri_ff, s) < priOf(pri_ff, int'(pick))))
            begin
                pick    = 2'(s);
                anyPick = 1'b1;
            end
        end
    end

    assign startMask = (state_ff == ST_IDLE && anyPick) ? (4'h1 << pick)
                                                        : 4'h0;
    assign curCtl  = ctl_ff[cur_ff][4*step_ff +: 4];
    assign curMux  = mux_ff[cur_ff][4*step_ff +: 4];
    assign pushEn  = (state_ff == ST_STORE);
    assign stepEnd = curCtl[CTL_END] ||
                     (step_ff == 3'(STEPS[cur_ff] - 1));
    assign avgOut  = 10'(acc_ff >> sac_ff);

    // Step engine: issue, wait, accumulate, store
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff  <= ST_IDLE;
            cur_ff    <= 2'd0;
            step_ff   <= 3'd0;
            avgCnt_ff <= 7'd0;
            acc_ff    <= 16'h0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                    if (anyPick)
                    begin
                        cur_ff    <= pick;
                        step_ff   <= 3'd0;
                        avgCnt_ff <= 7'd0;
                        acc_ff    <= 16'h0;
                        state_ff  <= ST_ISSUE;
                    end
                ST_ISSUE:
                    state_ff <= ST_WAIT;
                ST_WAIT:
                    if (convDone)
                    begin
                        acc_ff <= acc_ff + 16'(convData);
                        if (avgCnt_ff == 7'((1 << sac_ff) - 1))
                            state_ff <= ST_STORE;
                        else
                        begin
                            avgCnt_ff <= avgCnt_ff + 7'd1;
                            state_ff  <= ST_ISSUE;
                        end
                    end
                ST_STORE:
                begin
                    avgCnt_ff <= 7'd0;
                    acc_ff    <= 16'h0;
                    if (stepEnd)
                        state_ff <= ST_IDLE;
                    else
                    begin
                        step_ff  <= step_ff + 3'd1;
                        state_ff <= ST_ISSUE;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Converter request; start is one cycle per conversion
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            convReq_ff <= '0;
        else
        begin
            convReq_ff.start <= (state_ff == ST_ISSUE);
            convReq_ff.chan  <= curMux;
            convReq_ff.diff  <= curCtl[CTL_DIFF];
            convReq_ff.temp  <= curCtl[CTL_TEMP];
        end
    end

    // Result FIFOs, one circular buffer per sequencer
    generate
        for (genvar s = 0; s < NSEQ; s++)
        begin : g_fifo
            logic [9:0] mem_ff [MAX_DEPTH];
            logic [2:0] wr_ff, rd_ff;
            logic [3:0] cnt_ff;
            logic       push, pop;
            assign fifoFull[s]  = (cnt_ff == 4'(FDEPTH[s]));
            assign fifoEmpty[s] = (cnt_ff == 4'h0);
            assign push = pushEn && (cur_ff == 2'(s)) && !fifoFull[s];
            assign pop  = popMask[s];
            assign fifoHead[s] = mem_ff[rd_ff];
            assign fstat[s] = {19'h0, fifoFull[s], 3'h0, fifoEmpty[s],
                               1'b0, wr_ff, 1'b0, rd_ff};
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    wr_ff  <= 3'd0;
                    rd_ff  <= 3'd0;
                    cnt_ff <= 4'h0;
                    for (int i = 0; i < MAX_DEPTH; i++)
                        mem_ff[i] <= 10'h0;
                end
                else
                begin
                    if (push)
                    begin
                        mem_ff[wr_ff] <= avgOut;
                        wr_ff <= (wr_ff == 3'(FDEPTH[s] - 1)) ? 3'd0
                                 : wr_ff + 3'd1;
                    end
                    if (pop)
                        rd_ff <= (rd_ff == 3'(FDEPTH[s] - 1)) ? 3'd0
                                 : rd_ff + 3'd1;
                    cnt_ff <= cnt_ff + 4'(push) - 4'(pop);
                end
            end
        end
    endgenerate

    // Status event sources
    always_comb
    begin
        logic fifoRd;
        fifoRd  = rdAcc && inSeq(apbIn.paddr) &&
                  (apbIn.paddr[4:0] == SUB_FIFO);
        popMask = (fifoRd && popOk_ff) ? (4'h1 << seqOf(apbIn.paddr))
                                       : 4'h0;
        unfSet  = (fifoRd && !popOk_ff) ? (4'h1 << seqOf(apbIn.paddr))
                                        : 4'h0;
        ovfSet  = (pushEn && fifoFull[cur_ff]) ? (4'h1 << cur_ff)
                                               : 4'h0;
        risSet  = (pushEn && curCtl[CTL_IE]) ? (4'h1 << cur_ff)
                                             : 4'h0;
        iscClr  = (wrEn && apbIn.paddr == OFF_ISC) ? apbIn.pwdata[3:0]
                                                   : 4'h0;
    end

    // Sticky flags; hardware set wins over a same-cycle clear
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ris_ff <= 4'h0;
            ovf_ff <= 4'h0;
            unf_ff <= 4'h0;
        end
        else
        begin
            ris_ff <= (ris_ff & ~iscClr) | risSet;
            ovf_ff <= (ovf_ff & ~((wrEn && apbIn.paddr == OFF_OSTAT)
                      ? apbIn.pwdata[3:0] : 4'h0)) | ovfSet;
            unf_ff <= (unf_ff & ~((wrEn && apbIn.paddr == OFF_USTAT)
                      ? apbIn.pwdata[3:0] : 4'h0)) | unfSet;
        end
    end

    // Gated interrupt lines
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq_ff <= 4'h0;
        else
            irq_ff <= ris_ff & im_ff;
    end

    // Converter clock divider; ratio follows the crystal selection
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            divCnt_ff  <= 4'h0;
            convClk_ff <= 1'b0;
        end
        else if (divCnt_ff >= DIV_HALF[xtalSel] - 4'h1)
        begin
            divCnt_ff  <= 4'h0;
            convClk_ff <= !convClk_ff;
        end
        else
            divCnt_ff <= divCnt_ff + 4'h1;
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign convReq = convReq_ff;
    assign convClk = convClk_ff;
    assign irqOut  = irq_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Helper: sequencer addressed by the bus
    assign busSeq = seqOf(apbIn.paddr);

    // Helper: a better-priority enabled sequencer lost the pick
    logic badPick;
    always_comb
    begin
        badPick = 1'b0;
        for (int t = 0; t < NSEQ; t++)
            if (pending_ff[t] && actEn_ff[t] &&
                priOf(pri_ff, t) < priOf(pri_ff, int'(pick)))
                badPick = 1'b1;
    end

    property p_prio;
        (state_ff == ST_IDLE && anyPick) |-> !badPick;
    endproperty
    a_prio: assert property (p_prio)
        else $error("lower priority sequencer picked");

    property p_enabled;
        (state_ff == ST_IDLE && anyPick) |-> actEn_ff[pick];
    endproperty
    a_enabled: assert property (p_enabled)
        else $error("disabled sequencer started");

    property p_end;
        (state_ff == ST_STORE && curCtl[CTL_END]) |=> state_ff == ST_IDLE;
    endproperty
    a_end: assert property (p_end)
        else $error("sequence ran past end step");

    property p_ie;
        (state_ff == ST_STORE && curCtl[CTL_IE]) |=> ris_ff[$past(cur_ff)]
            ##1 irqOut[$past(cur_ff, 2)] == im_ff[$past(cur_ff, 2)];
    endproperty
    a_ie: assert property (p_ie)
        else $error("step event not raised or gated wrongly");

    property p_isc_read;
        (setup && !apbIn.pwrite && apbIn.paddr == OFF_ISC)
            |=> prdata == {28'h0, $past(ris_ff) & $past(im_ff)};
    endproperty
    a_isc_read: assert property (p_isc_read)
        else $error("masked status is not raw AND gate");

    property p_clear;
        (iscClr != 4'h0)
            |=> (ris_ff & $past(iscClr) & ~$past(risSet)) == 4'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("write one did not clear event");

    property p_ovf;
        (pushEn && fifoFull[cur_ff]) |=> ovf_ff[$past(cur_ff)];
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow not recorded");

    property p_unf;
        (rdAcc && inSeq(apbIn.paddr) && apbIn.paddr[4:0] == SUB_FIFO
         && !popOk_ff) |=> unf_ff[$past(busSeq)];
    endproperty
    a_unf: assert property (p_unf)
        else $error("underflow not recorded");

    property p_noavg;
        (state_ff == ST_WAIT && convDone && sac_ff == 3'h0)
            |=> state_ff == ST_STORE ##1 !fifoEmpty[$past(cur_ff, 2)];
    endproperty
    a_noavg: assert property (p_noavg)
        else $error("result did not pass straight to FIFO");

endmodule : assc_sequencer_ctl

// ===== src/assc_pkg.sv
package assc_pkg;

    // Block geometry
    localparam int NSEQ      = 4;
    localparam int MAX_STEPS = 8;
    localparam int MAX_DEPTH = 8;
    localparam int RES_W     = 10;

    // Register byte offsets
    localparam logic [11:0] OFF_ACT   = 12'h000;
    localparam logic [11:0] OFF_RIS   = 12'h004;
    localparam logic [11:0] OFF_IM    = 12'h008;
    localparam logic [11:0] OFF_ISC   = 12'h00C;
    localparam logic [11:0] OFF_OSTAT = 12'h010;
    localparam logic [11:0] OFF_EMUX  = 12'h014;
    localparam logic [11:0] OFF_USTAT = 12'h018;
    localparam logic [11:0] OFF_PRI   = 12'h020;
    localparam logic [11:0] OFF_PSSI  = 12'h028;
    localparam logic [11:0] OFF_SAC   = 12'h030;
    localparam logic [11:0] OFF_SEQ   = 12'h040;
    localparam logic [11:0] SEQ_SPAN  = 12'h080;
    localparam int          SEQ_SHIFT = 5;
    localparam logic [4:0]  SUB_MUX   = 5'h00;
    localparam logic [4:0]  SUB_CTL   = 5'h04;
    localparam logic [4:0]  SUB_FIFO  = 5'h08;
    localparam logic [4:0]  SUB_FSTAT = 5'h0C;

    // Reset values and field masks
    localparam logic [15:0] RST_PRI  = 16'h3210;
    localparam logic [15:0] PRI_MASK = 16'h3333;
    localparam logic [2:0]  RST_SAC  = 3'h0;
    localparam logic [2:0]  SAC_MAX  = 3'h6;

    // Result FIFO status field positions
    localparam int FST_TAIL  = 0;
    localparam int FST_HEAD  = 4;
    localparam int FST_EMPTY = 8;
    localparam int FST_FULL  = 12;

    // Step control nibble bit positions
    localparam int CTL_DIFF = 0;
    localparam int CTL_END  = 1;
    localparam int CTL_IE   = 2;
    localparam int CTL_TEMP = 3;

    // Trigger codes in the event-select fields
    localparam logic [3:0] TRIG_SW     = 4'h0;
    localparam logic [3:0] TRIG_EXT_LO = 4'h1;
    localparam logic [3:0] TRIG_EXT_HI = 4'h4;
    localparam logic [3:0] TRIG_ALWAYS = 4'hF;

    // Converter clock half-period per crystal selection
    localparam logic [3:0] DIV_HALF [4] = '{4'h1, 4'h1, 4'h2, 4'h3};

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ISSUE = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_STORE = 4'b1000
    } assc_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } assc_apb_req_t;

    typedef struct packed {
        logic       start;
        logic [3:0] chan;
        logic       diff;
        logic       temp;
    } assc_conv_req_t;

endpackage : assc_pkg

// ===== tb/assc_conv_model.sv
`timescale 1ns/1ps
// Converter core stand-in: fixed latency, result tagged by channel
module assc_conv_model
#(
    parameter int LAT = 3
)
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    // Converter link
    input  wire assc_pkg::assc_conv_req_t convReq,
    output logic                          convDone,
    output logic [9:0]                    convData
);
    import assc_pkg::*;
    int cnt;
    logic odd;
    // Data toggles outside the done cycle so stale values never match;
    // results alternate in value so that averaging shows in the sum
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 0;
            odd <= 1'b0;
            convDone <= 1'b0;
            convData <= 10'h3FF;
        end
        else
        begin
            convDone <= (cnt == 1);
            convData <= (cnt == 1) ? {(odd ? 6'h00 : 6'h3C), convReq.chan}
                                   : ~convData;
            odd <= odd ^ (cnt == 1);
            cnt <= convReq.start ? LAT : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule : assc_conv_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import assc_pkg::*;
    logic mclk = 0, nrst = 0, convDone, pready, pslverr;
    assc_apb_req_t  apbIn = '0;
    assc_conv_req_t convReq;
    logic [31:0] prdata, rd;
    logic [9:0]  convData;
    logic [3:0]  irqOut;
    logic        err, c0, convClk;
    logic [1:0]  xtalSel = 2'h2;
    logic [3:0]  extTrig = 4'h0;
    int mismatches = 0, samples_checked = 0;
    always #20 mclk = ~mclk;
    assc_sequencer_ctl i_dut (.mclk(mclk), .nrst(nrst), .apbIn(apbIn),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extTrig(extTrig), .xtalSel(xtalSel), .convReq(convReq),
        .convDone(convDone), .convData(convData), .convClk(convClk),
        .irqOut(irqOut));
    assc_conv_model i_conv (.mclk(mclk), .nrst(nrst), .convReq(convReq),
        .convDone(convDone), .convData(convData));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // Setup, access until pready at a rising edge, release right after it
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge mclk);
        apbIn <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apbIn.penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apbIn.psel <= 1'b0;
        apbIn.penable <= 1'b0;
    endtask : xfer
    // Bounded poll until a raw status bit shows up
    task automatic wait_raw(input logic [31:0] bits);
        int n;
        n = 0;
        do
        begin
            xfer(0, OFF_RIS, 0);
            n++;
        end
        while ((rd & bits) !== bits && n < 40);
    endtask : wait_raw
    initial
    begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        xfer(0, OFF_PRI, 0);  chk(rd, 32'h3210);
        xfer(0, OFF_SAC, 0);  chk(rd, 32'h0);
        xfer(0, 12'h0AC, 0);  chk(rd, 32'h100);
        xfer(0, 12'h03C, 0);  chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Sequencer 3 programmed and software-started while disabled, then enabled and started again
        xfer(1, 12'h0A0, 32'h5);
        xfer(1, 12'h0A4, 32'h6);
        xfer(1, OFF_EMUX, 32'h0);
        xfer(1, OFF_PSSI, 32'h8);
        repeat (20) @(posedge mclk);
        xfer(0, OFF_RIS, 0);  chk(rd, 32'h0);
        xfer(1, OFF_IM, 32'h8);
        xfer(1, OFF_ACT, 32'h8);
        xfer(1, OFF_PSSI, 32'h8);
        wait_raw(32'h8);      chk(rd, 32'h8);
        xfer(0, 12'h0AC, 0);  chk(rd & 32'h1100, 32'h1000);
        xfer(0, OFF_ISC, 0);  chk(rd, 32'h8);
        chk(irqOut, 4'h8);
        xfer(1, OFF_IM, 32'h0);
        xfer(0, OFF_ISC, 0);  chk(rd, 32'h0);
        chk(irqOut, 4'h0);
        xfer(1, OFF_ISC, 32'h0);
        xfer(0, OFF_RIS, 0);  chk(rd, 32'h8);
        xfer(1, OFF_ISC, 32'h8);
        xfer(0, OFF_RIS, 0);  chk(rd, 32'h0);
        // Second result into the one-deep FIFO is dropped
        xfer(1, OFF_PSSI, 32'h8);
        wait_raw(32'h8);
        xfer(0, OFF_OSTAT, 0); chk(rd, 32'h8);
        xfer(0, 12'h0A8, 0);  chk(rd, 32'h3C5);
        xfer(0, 12'h0AC, 0);  chk(rd & 32'h1100, 32'h100);
        xfer(0, 12'h0A8, 0);
        xfer(0, OFF_USTAT, 0); chk(rd, 32'h8);
        // Four-sample average of alternating results, then a pin trigger
        xfer(1, OFF_ISC, 32'h8);
        xfer(1, OFF_SAC, 32'h2);
        xfer(1, OFF_PSSI, 32'h8);
        wait_raw(32'h8);
        xfer(0, 12'h0A8, 0);  chk(rd, 32'h1E5);
        xfer(1, OFF_ISC, 32'h8);
        xfer(1, OFF_EMUX, 32'h4000);
        extTrig <= 4'h8;
        @(posedge mclk);
        extTrig <= 4'h0;
        wait_raw(32'h8);      chk(rd, 32'h8);
        // Converter clock toggles once per half-period count of edges
        c0 = convClk;
        repeat (DIV_HALF[2]) @(posedge mclk);
        chk({31'h0, convClk}, {31'h0, !c0});
        xtalSel <= 2'h0;
        repeat (2) @(posedge mclk);
        c0 = convClk;
        repeat (DIV_HALF[0]) @(posedge mclk);
        chk({31'h0, convClk}, {31'h0, !c0});
        end_sim();
    end
    // Hang guard, well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_sim();
    end
endmodule : tb_top
